// [verilog/vectored_priority_interrupt_ctrl.sv]
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module vectored_priority_interrupt_ctrl
    import vpic_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic [11:0]         awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [11:0]         araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic [TRAP_NUM-1:0] trapReq,
    input  wire logic [SRC_NUM-1:0]  srcReq,
    input  wire logic [2:0]          cpuPriority,
    output logic                     irqReq,
    input  wire logic                irqAck,
    output logic [6:0]               takenVector,
    output logic                     pmRdEn,
    output logic [23:0]              pmRdAddr,
    input  wire logic [23:0]         pmRdData,
    output logic [23:0]              handlerAddr,
    output logic                     handlerValid,
    input  wire logic                retReq,
    output logic                     retDone
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        seq_state_e                  state;        // Sequencer
        logic [SRC_NUM-1:0][2:0]     prio;         // Priority fields
        logic                        altSel;       // Alternate table select
        logic [6:0]                  takenVec;     // Vector being serviced
        logic                        fetchAlt;     // Table chosen at acceptance
        logic [23:0]                 pmRdAddr;     // Vector fetch address
        logic                        pmRdEn;       // Vector fetch strobe
        logic [23:0]                 handlerAddr;  // Handler start
        logic                        handlerValid; // Handler pulse
        logic                        retDone;      // Return pulse
        logic [1:0]                  retCnt;       // Return countdown
        logic                        awHeld;       // Write address captured
        logic [11:0]                 awAddr;
        logic                        wHeld;        // Write data captured
        logic [31:0]                 wData;
        logic [3:0]                  wStrb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } ctrl_s;

    ctrl_s                           s_r;          // Registered state
    ctrl_s                           s_nxt;        // Next state
    logic [3:0]                      winLvl;       // Winning level, 0 when none
    logic [6:0]                      winVec;       // Winning vector
    logic [PRIO_REG_NUM-1:0][31:0]   prioView;     // Priority words as read
    logic [23:0]                     tableBase;    // Base of the selected table
    logic [SRC_NUM-1:0]              srcOn;        // Source has a nonzero level

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    // Traps first, then sources; strict compare keeps lower vector on ties
    always_comb begin
        winLvl = 4'h0;
        winVec = 7'h00;
        for (int t = 0; t < TRAP_NUM; t++) begin
            if (trapReq[t] && winLvl != TRAP_LEVEL) begin
                winLvl = TRAP_LEVEL;
                winVec = 7'(t);
            end
        end
        for (int i = 0; i < SRC_NUM; i++) begin
            // Disabled sources never compete
            if (srcReq[i] && s_r.prio[i] != PRIO_OFF && {1'b0, s_r.prio[i]} > winLvl) begin
                winLvl = {1'b0, s_r.prio[i]};
                winVec = 7'(TRAP_SLOTS + i);
            end
        end
    end

    // Single request, gated by core execution priority
    assign irqReq = (s_r.state == ST_IDLE) && (winLvl > {1'b0, cpuPriority});

    // Table choice, layout shared by both tables
    assign tableBase = s_r.altSel ? ALT_BASE : PRIMARY_BASE;

    ////////////////////////////////////////////////////////////////////////////
    // Priority read view

    // Unused fields and bits read zero
    for (genvar k = 0; k < PRIO_REG_NUM; k++) begin : g_view
        for (genvar j = 0; j < 4; j++) begin : g_field
            if (k * 4 + j < SRC_NUM) begin : g_used
                assign prioView[k][j*FIELD_STRIDE +: FIELD_STRIDE] =
                    {1'b0, s_r.prio[k*4+j]};
            end else begin : g_unused
                assign prioView[k][j*FIELD_STRIDE +: FIELD_STRIDE] = 4'h0;
            end
        end
        assign prioView[k][31:16] = 16'h0000;
    end

    // Enabled map, kept apart from the arbiter so the checks see it independently
    for (genvar i = 0; i < SRC_NUM; i++) begin : g_on
        assign srcOn[i] = (s_r.prio[i] != PRIO_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        int wIdx;
        int rIdx;
        wIdx = int'(s_r.awAddr[11:2]);
        rIdx = int'(araddr[11:2]);
        s_nxt = s_r;
        s_nxt.handlerValid = 1'b0;
        s_nxt.retDone = 1'b0;
        s_nxt.pmRdEn = 1'b0;

        // Sequencer
        case (s_r.state)
            // First cycle after reset: start at address zero, no table involved
            ST_BOOT: begin
                s_nxt.handlerAddr = RESET_PC;
                s_nxt.handlerValid = 1'b1;
                s_nxt.state = ST_IDLE;
            end
            // Accept the winner and launch the vector fetch
            ST_IDLE: begin
                if (irqReq && irqAck) begin
                    s_nxt.takenVec = winVec;
                    s_nxt.fetchAlt = s_r.altSel;
                    s_nxt.pmRdAddr = tableBase + {16'h0000, winVec, 1'b0};
                    s_nxt.pmRdEn = 1'b1;
                    s_nxt.state = ST_FETCH;
                end
            end
            // Memory answers one cycle after the strobe
            ST_FETCH: begin
                s_nxt.state = ST_WAIT;
            end
            // Entry word is the handler start
            ST_WAIT: begin
                s_nxt.handlerAddr = pmRdData;
                s_nxt.handlerValid = 1'b1;
                s_nxt.state = ST_ACTIVE;
            end
            // Handler running until return
            ST_ACTIVE: begin
                if (retReq) begin
                    s_nxt.retCnt = RET_CNT_INIT;
                    s_nxt.state = ST_RETURN;
                end
            end
            // Fixed return countdown
            ST_RETURN: begin
                if (s_r.retCnt == 2'h0) begin
                    s_nxt.retDone = 1'b1;
                    s_nxt.state = ST_IDLE;
                end else begin
                    s_nxt.retCnt = s_r.retCnt - 2'h1;
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase

        // Write address and data, either order
        if (awvalid && awready) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = wdata;
            s_nxt.wStrb = wstrb;
        end

        // Both halves present: apply the write
        if (s_r.awHeld && s_r.wHeld) begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (wIdx < PRIO_REG_NUM) begin
                // Each field lives in its own nibble; lanes gate pairs
                for (int j = 0; j < 4; j++) begin
                    if (wIdx * 4 + j < SRC_NUM && s_r.wStrb[j/2]) begin
                        s_nxt.prio[wIdx*4+j] = s_r.wData[j*FIELD_STRIDE +: 3];
                    end
                end
            end else if (s_r.awAddr[11:2] == CTRL_OFF[11:2]) begin
                if (s_r.wStrb[1]) begin
                    s_nxt.altSel = s_r.wData[ALT_SEL_BIT];
                end
            end else if (s_r.awAddr[11:2] != STATUS_OFF[11:2]) begin
                // Unmapped address
                s_nxt.bresp = RESP_SLVERR;
            end
        end

        // Write response taken
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Read response taken
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Read request
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            if (rIdx < PRIO_REG_NUM) begin
                s_nxt.rdata = prioView[rIdx];
            end else if (araddr[11:2] == CTRL_OFF[11:2]) begin
                s_nxt.rdata[ALT_SEL_BIT] = s_r.altSel;
            end else if (araddr[11:2] == STATUS_OFF[11:2]) begin
                s_nxt.rdata = {16'h0000, irqReq, winVec, 4'h0, winLvl};
            end else begin
                s_nxt.rresp = RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset clears everything but the priority fields, which load level 4, and parks the sequencer in boot
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.state <= ST_BOOT;
            s_r.prio <= {SRC_NUM{PRIO_RESET}};
            s_r.handlerAddr <= RESET_PC;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready      = !s_r.awHeld && !s_r.bvalid;
    assign wready       = !s_r.wHeld && !s_r.bvalid;
    assign bvalid       = s_r.bvalid;
    assign bresp        = s_r.bresp;
    assign arready      = !s_r.rvalid;
    assign rvalid       = s_r.rvalid;
    assign rdata        = s_r.rdata;
    assign rresp        = s_r.rresp;
    assign takenVector  = s_r.takenVec;
    assign pmRdEn       = s_r.pmRdEn;
    assign pmRdAddr     = s_r.pmRdAddr;
    assign handlerAddr  = s_r.handlerAddr;
    assign handlerValid = s_r.handlerValid;
    assign retDone      = s_r.retDone;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Request only when the winner beats the core
    req_gate_a: assert property (
        irqReq |-> (winLvl > {1'b0, cpuPriority}) && winLvl != 4'h0)
        else $error("request raised without a winner above core priority");

    // Acceptance to handler in three cycles
    entry_lat_a: assert property (
        (irqReq && irqAck) |=> pmRdEn ##1 !handlerValid ##1 handlerValid)
        else $error("entry latency not three cycles");

    // Fetch address from selected table
    fetch_addr_a: assert property (
        pmRdEn |-> pmRdAddr == ($past(s_r.altSel) ? ALT_BASE : PRIMARY_BASE)
                              + {16'h0000, takenVector, 1'b0})
        else $error("vector fetch address wrong");

    // Alternate table sits right after the primary one
    alt_place_a: assert property (
        (pmRdEn && s_r.fetchAlt) |-> pmRdAddr - {16'h0000, takenVector, 1'b0}
                                     == 24'(PRIMARY_BASE + 2 * VEC_NUM))
        else $error("alternate table misplaced");

    // Handler address is the fetched entry
    handler_data_a: assert property (
        (pmRdEn ##2 handlerValid) |-> handlerAddr == $past(pmRdData))
        else $error("handler address differs from vector entry");

    // Return completes after fixed latency
    return_lat_a: assert property (
        (s_r.state == ST_ACTIVE && retReq) |-> !retDone [*4] ##1 retDone)
        else $error("return latency not four cycles");

    // Boot starts at zero with priorities at level 4
    boot_zero_a: assert property (
        (s_r.state == ST_BOOT) |-> s_r.prio == {SRC_NUM{PRIO_RESET}}
                                   ##1 (handlerValid && handlerAddr == RESET_PC))
        else $error("reset did not lead to address zero");

    // Traps beat every maskable source
    trap_win_a: assert property (
        (irqReq && irqAck && trapReq != '0) |=> takenVector < 7'(TRAP_NUM))
        else $error("maskable source beat a trap");

    // Tie between first two sources goes to the lower vector
    tie_break_a: assert property (
        (irqReq && irqAck && trapReq == '0 && srcReq[0] && srcReq[1]
         && s_r.prio[0] == s_r.prio[1] && s_r.prio[0] != PRIO_OFF
         && winLvl == {1'b0, s_r.prio[0]}) |=> takenVector == 7'(TRAP_SLOTS))
        else $error("tie not broken toward lower vector");

    // Disabled sources never raise a request
    disabled_a: assert property (
        (trapReq == '0 && (srcReq & srcOn) == '0) |-> !irqReq)
        else $error("disabled source raised a request");

    boot_c:   cover property (s_r.state == ST_BOOT ##1 handlerValid);
    alt_c:    cover property (pmRdEn && s_r.fetchAlt);
    trap_c:   cover property (irqReq && irqAck && trapReq != '0);
    return_c: cover property (retDone);

endmodule

// [verilog/vpic_pkg.sv]
package vpic_pkg;

    // Source counts and vector table shape
    localparam int          SRC_NUM       = 67;             // Maskable sources
    localparam int          TRAP_NUM      = 5;              // Non-maskable traps
    localparam int          TRAP_SLOTS    = 8;              // Trap entries ahead of sources
    localparam int          SRC_SLOTS     = 118;            // Source entries in a table
    localparam int          VEC_NUM       = TRAP_SLOTS + SRC_SLOTS;
    localparam int          PRIO_REG_NUM  = (SRC_NUM + 3) / 4;

    // Program memory placement of the tables, word addresses
    localparam logic [23:0] PRIMARY_BASE  = 24'h000004;
    localparam logic [23:0] ALT_BASE      = 24'(PRIMARY_BASE + 2 * VEC_NUM);
    localparam logic [23:0] RESET_PC      = 24'h000000;

    // Priority fields
    localparam logic [2:0]  PRIO_RESET    = 3'h4;           // Level 4 after reset
    localparam logic [2:0]  PRIO_OFF      = 3'h0;           // Source disabled
    localparam logic [3:0]  TRAP_LEVEL    = 4'h8;           // Above every user level

    // Register byte offsets
    localparam logic [11:0] PRIO_BASE_OFF = 12'h000;        // Four fields per word
    localparam logic [11:0] CTRL_OFF      = 12'h048;        // interrupt_control_two
    localparam logic [11:0] STATUS_OFF    = 12'h04C;        // Winner and request
    localparam int          ALT_SEL_BIT   = 15;
    localparam int          FIELD_STRIDE  = 4;

    // Return latency in cycles, request to done pulse
    localparam int          RETURN_LATENCY = 4;
    localparam logic [1:0]  RET_CNT_INIT   = 2'(RETURN_LATENCY - 2);

    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_BOOT   = 6'h01,
        ST_IDLE   = 6'h02,
        ST_FETCH  = 6'h04,
        ST_WAIT   = 6'h08,
        ST_ACTIVE = 6'h10,
        ST_RETURN = 6'h20
    } seq_state_e;

endpackage

// [verif/prog_mem_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Program memory holding both vector tables, one cycle read latency
module prog_mem_model
    import vpic_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        pmRdEn,
    input  wire logic [23:0] pmRdAddr,
    output logic      [23:0] pmRdData
);
    // Handler address pattern, distinct per entry
    localparam logic [23:0] FILL = 24'h5A5A00;

    ////////////////////////////////////////////////////////////////////////////
    // Entry read on the strobe; otherwise the bus churns every cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pmRdData <= 24'h000000;
        end else if (pmRdEn) begin
            pmRdData <= FILL ^ pmRdAddr;
        end else begin
            pmRdData <= ~pmRdData; // Stale data never looks valid
        end
    end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the vectored interrupt controller
module testbench;
    import vpic_pkg::*;

    // Bus, core and memory side signals
    logic                ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready, irqReq, irqAck, pmRdEn;
    logic                handlerValid, retReq, retDone;
    logic [11:0]         awaddr, araddr;
    logic [31:0]         wdata, rdata, rd;
    logic [3:0]          wstrb;
    logic [1:0]          bresp, rresp, rs;
    logic [TRAP_NUM-1:0] trapReq;
    logic [SRC_NUM-1:0]  srcReq;
    logic [2:0]          cpuPriority;
    logic [6:0]          takenVector;
    logic [23:0]         pmRdAddr, pmRdData, handlerAddr;
    int                  n_mismatch, checked;

    ////////////////////////////////////////////////////////////////////////////
    // Design and program memory
    vectored_priority_interrupt_ctrl i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .trapReq(trapReq), .srcReq(srcReq),
        .cpuPriority(cpuPriority), .irqReq(irqReq), .irqAck(irqAck),
        .takenVector(takenVector), .pmRdEn(pmRdEn), .pmRdAddr(pmRdAddr),
        .pmRdData(pmRdData), .handlerAddr(handlerAddr), .handlerValid(handlerValid),
        .retReq(retReq), .retDone(retDone));
    prog_mem_model i_mem (.ref_clk(ref_clk), .reset_n(reset_n), .pmRdEn(pmRdEn),
        .pmRdAddr(pmRdAddr), .pmRdData(pmRdData));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Bus write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    // Bus read into rd and rs
    task automatic rd_word(input logic [11:0] a);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask

    // Accept the pending request and follow the vector fetch
    task automatic take(input logic [6:0] v, input logic [23:0] base);
        logic [23:0] a;
        int n;
        a = base + 24'(2 * v);
        n = 0;
        @(posedge ref_clk);
        while (irqReq !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        chk("irqReq", 32'(irqReq), 32'h1);
        irqAck <= 1'b1;
        @(posedge ref_clk);
        irqAck <= 1'b0;
        #1;
        chk("pmRdEn", 32'(pmRdEn), 32'h1);
        chk("pmRdAddr", 32'(pmRdAddr), 32'(a));
        chk("takenVector", 32'(takenVector), 32'(v));
        chk("irqReq nested", 32'(irqReq), 32'h0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("handlerValid", 32'(handlerValid), 32'h1);
        chk("handlerAddr", 32'(handlerAddr), 32'(24'h5A5A00 ^ a));
    endtask

    // Drop requests and return from the handler
    task automatic ret();
        @(posedge ref_clk);
        srcReq <= '0;
        trapReq <= '0;
        retReq <= 1'b1;
        @(posedge ref_clk);
        retReq <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("retDone early", 32'(retDone), 32'h0);
        @(posedge ref_clk);
        #1;
        chk("retDone", 32'(retDone), 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset start at address zero
    task automatic t_reset();
        @(posedge ref_clk);
        #1;
        chk("reset handlerValid", 32'(handlerValid), 32'h1);
        chk("reset handlerAddr", 32'(handlerAddr), 32'h0);
        chk("reset irqReq", 32'(irqReq), 32'h0);
    endtask

    // Reset values, unused bits, unmapped place
    task automatic t_regs();
        rd_word(12'h000);
        chk("prio word0", rd, 32'h4444);
        rd_word(12'h040);
        chk("prio word16", rd, 32'h0444);
        rd_word(CTRL_OFF);
        chk("ctrl reset", rd, 32'h0);
        wr(12'h004, 32'hFFFFFFFF, RESP_OKAY);
        rd_word(12'h004);
        chk("prio unused bits", rd, 32'h7777);
        wr(12'h004, 32'h4444, RESP_OKAY);
        wr(12'h044, 32'h1, RESP_SLVERR);
        rd_word(12'h044);
        chk("unmapped rresp", 32'(rs), 32'(RESP_SLVERR));
    endtask

    // Every level against three core priorities
    task automatic t_levels();
        @(posedge ref_clk);
        srcReq <= SRC_NUM'(1);
        for (int l = 0; l < 8; l++) begin
            wr(12'h000, 32'h4440 | 32'(l), RESP_OKAY);
            for (int c = 0; c < 8; c += 3) begin
                @(posedge ref_clk);
                cpuPriority <= 3'(c);
                @(posedge ref_clk);
                #1;
                chk("irqReq level", 32'(irqReq), 32'(l > c));
            end
        end
        wr(12'h000, 32'h4444, RESP_OKAY);
        @(posedge ref_clk);
        cpuPriority <= 3'h0;
    endtask

    // Tie on level, then a higher level
    task automatic t_take();
        @(posedge ref_clk);
        srcReq <= SRC_NUM'(3);
        rd_word(STATUS_OFF);
        chk("status", rd, 32'h8804);
        take(7'd8, 24'h000004);
        ret();
        wr(12'h000, 32'h4644, RESP_OKAY);
        @(posedge ref_clk);
        srcReq <= SRC_NUM'(7);
        take(7'd10, 24'h000004);
        ret();
    endtask

    // Traps outrank sources and ignore core priority
    task automatic t_trap();
        @(posedge ref_clk);
        cpuPriority <= 3'h7;
        srcReq <= SRC_NUM'(1);
        trapReq <= 5'h11;
        take(7'd0, 24'h000004);
        ret();
        @(posedge ref_clk);
        trapReq <= 5'h10;
        take(7'd4, 24'h000004);
        ret();
        @(posedge ref_clk);
        cpuPriority <= 3'h0;
    endtask

    // Alternate table with the last source
    task automatic t_alt();
        wr(CTRL_OFF, 32'h8000, RESP_OKAY);
        rd_word(CTRL_OFF);
        chk("alt select", rd, 32'h8000);
        @(posedge ref_clk);
        srcReq <= SRC_NUM'(1) << 66;
        take(7'd74, 24'h000100);
        ret();
        wr(CTRL_OFF, 32'h0, RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_mismatch = 0;
        checked = 0;
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, irqAck, retReq} = '0;
        {awaddr, wdata, wstrb, araddr, trapReq, srcReq, cpuPriority} = '0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_levels();
        t_take();
        t_trap();
        t_alt();
        finish_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
endmodule
